//--- fopc_params.svh
// Offsets, field positions, reset values and timing counts of the flash sequencer
`ifndef FOPC_PARAMS_SVH
`define FOPC_PARAMS_SVH
`define FOPC_CLK_MHZ         100
`define FOPC_OFF_CTRL        8'h00
`define FOPC_OFF_STAT        8'h04
`define FOPC_OFF_IRQ_STAT    8'h08
`define FOPC_OFF_IRQ_MASK    8'h0C
`define FOPC_OFF_CONFIG      8'h10
`define FOPC_B_HVE           0
`define FOPC_B_ERASE         1
`define FOPC_B_PSUS          2
`define FOPC_B_ESUS          3
`define FOPC_B_LOWPWR        4
`define FOPC_B_CHK_EN        8
`define FOPC_B_CHK_SUS       9
`define FOPC_B_NO_BKPT       10
`define FOPC_B_MRSEL         11
`define FOPC_S_DONE          0
`define FOPC_S_BUSY          1
`define FOPC_S_READY         2
`define FOPC_S_CHK_FIN       8
`define FOPC_S_AIBUSY        9
`define FOPC_I_DONE          0
`define FOPC_I_CHK_FIN       1
`define FOPC_I_READY         2
`define FOPC_CTRL_RST        32'h0000_0000
`define FOPC_MASK_RST        3'h0
`define FOPC_OPLEN_RST       16'h0100
// Times in nanoseconds, counts derived at 10 ns per cycle
`define FOPC_T_PSUS_NS       9400
`define FOPC_T_ESUS_NS       16000
`define FOPC_T_MRSTOP_NS     10360
`define FOPC_T_AISTOP_NS     80
`define FOPC_T_DROV_NS       16000
`define FOPC_CYC(ns)         ((ns) * `FOPC_CLK_MHZ / 1000)
`define FOPC_C_PSUS          (`FOPC_CYC(`FOPC_T_PSUS_NS) + 4)
`define FOPC_C_ESUS          (`FOPC_CYC(`FOPC_T_ESUS_NS) + 4)
`define FOPC_C_MRSTOP        (`FOPC_CYC(`FOPC_T_MRSTOP_NS) + 4)
`define FOPC_C_AISTOP        (`FOPC_CYC(`FOPC_T_AISTOP_NS) + 15)
`define FOPC_C_DROV          (`FOPC_CYC(`FOPC_T_DROV_NS) + 7)
`endif

//--- fopc_pkg.sv
// Types shared by the flash sequencer
package fopc_pkg;
  typedef enum logic [4:0] {
    FOPC_IDLE = 5'h01,
    FOPC_RUN  = 5'h02,
    FOPC_STOP = 5'h04,
    FOPC_SUSP = 5'h08,
    FOPC_HALT = 5'h10
  } fopc_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } fopc_bus_t;
endpackage

//--- fopc_timer.sv
// Down counter that pulses once when a loaded delay runs out
`timescale 1ns/1ps
module fopc_timer (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_load,
  input  wire logic [15:0] i_count,
  input  wire logic        i_cancel,
  output logic             o_expire,
  output logic             o_busy
);
  logic [15:0] cnt_r;
  logic        busy_r;
  logic        exp_r;
  wire         last = busy_r && (cnt_r == 16'h0001);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || i_cancel) begin
      cnt_r  <= 16'h0000;
      busy_r <= 1'b0;
      exp_r  <= 1'b0;
    end else if (i_load) begin
      cnt_r  <= i_count;
      busy_r <= 1'b1;
      exp_r  <= 1'b0;
    end else begin
      cnt_r  <= busy_r ? cnt_r - 16'h0001 : cnt_r;
      busy_r <= busy_r && !last;
      exp_r  <= last;
    end
  end

  assign o_expire = exp_r;
  assign o_busy   = busy_r;
endmodule

//--- fopc_core.sv
// Program/erase and integrity-check sequencer with register port and interrupt
`timescale 1ns/1ps
`include "fopc_params.svh"

module fopc_core (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_ai_bkpt,
  output logic [31:0]      o_rdata,
  output logic             o_irq,
  output logic             o_hv_on,
  output logic             o_ai_run
);
  fopc_pkg::fopc_bus_t bus;
  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // Breakpoint input comes from the array side, so it is synchronised
  logic bk_s1_r;
  logic bk_s2_r;
  always_ff @(posedge i_ref_clk) begin
    bk_s1_r <= i_rst_n ? i_ai_bkpt : 1'b0;
    bk_s2_r <= i_rst_n ? bk_s1_r : 1'b0;
  end

  // Register file
  logic [31:0] ctrl_r;
  logic [2:0]  ist_r;
  logic [2:0]  mask_r;
  logic [15:0] oplen_r;
  logic [31:0] rdata_r;
  logic [31:0] status;

  wire sel_ctrl = bus.addr == `FOPC_OFF_CTRL;
  wire sel_stat = bus.addr == `FOPC_OFF_STAT;
  wire sel_ist  = bus.addr == `FOPC_OFF_IRQ_STAT;
  wire sel_mask = bus.addr == `FOPC_OFF_IRQ_MASK;
  wire sel_cfg  = bus.addr == `FOPC_OFF_CONFIG;
  wire wr_ctrl  = bus.wr && sel_ctrl;
  wire [31:0] ctrl_nxt = wr_ctrl ? bus.wdata : ctrl_r;

  function automatic logic fell(input logic [31:0] o, input logic [31:0] n, input int b);
    fell = o[b] && !n[b];
  endfunction
  function automatic logic rose(input logic [31:0] o, input logic [31:0] n, input int b);
    rose = !o[b] && n[b];
  endfunction

  wire hv_rise   = wr_ctrl && rose(ctrl_r, bus.wdata, `FOPC_B_HVE);
  wire hv_fall   = wr_ctrl && fell(ctrl_r, bus.wdata, `FOPC_B_HVE);
  wire psus_set  = wr_ctrl && rose(ctrl_r, bus.wdata, `FOPC_B_PSUS);
  wire esus_set  = wr_ctrl && rose(ctrl_r, bus.wdata, `FOPC_B_ESUS);
  wire sus_clr   = wr_ctrl && bus.wdata[`FOPC_B_HVE]
                   && (fell(ctrl_r, bus.wdata, `FOPC_B_PSUS)
                       || fell(ctrl_r, bus.wdata, `FOPC_B_ESUS));
  wire ai_rise   = wr_ctrl && rose(ctrl_r, bus.wdata, `FOPC_B_CHK_EN);
  wire ai_fall   = wr_ctrl && fell(ctrl_r, bus.wdata, `FOPC_B_CHK_EN);
  wire ais_set   = wr_ctrl && rose(ctrl_r, bus.wdata, `FOPC_B_CHK_SUS);
  wire ai_resume = wr_ctrl && (fell(ctrl_r, bus.wdata, `FOPC_B_CHK_SUS)
                               || fell(ctrl_r, bus.wdata, `FOPC_B_NO_BKPT));
  wire lp_exit   = wr_ctrl && fell(ctrl_r, bus.wdata, `FOPC_B_LOWPWR);

  logic        ready_r;
  logic [15:0] rec_r;

  // Program/erase sequencer
  fopc_pkg::fopc_state_t pe_r;
  fopc_pkg::fopc_state_t pe_nxt;
  logic        done_r;
  logic        done_nxt;
  logic        pe_load;
  logic [15:0] pe_cnt;
  wire         pe_exp;
  wire         is_erase = ctrl_r[`FOPC_B_ERASE];

  always_comb begin
    pe_nxt   = pe_r;
    done_nxt = done_r;
    pe_load  = 1'b0;
    pe_cnt   = oplen_r;
    case (pe_r)
      fopc_pkg::FOPC_IDLE: begin
        if (hv_rise && ready_r) begin
          pe_nxt   = fopc_pkg::FOPC_RUN;
          done_nxt = 1'b0;
          pe_load  = 1'b1;
        end
      end
      fopc_pkg::FOPC_RUN: begin
        if (hv_fall) begin
          pe_nxt  = fopc_pkg::FOPC_STOP;
          pe_load = 1'b1;
          pe_cnt  = 16'(`FOPC_C_ESUS);
        end else if (psus_set && !is_erase) begin
          pe_nxt  = fopc_pkg::FOPC_STOP;
          pe_load = 1'b1;
          pe_cnt  = 16'(`FOPC_C_PSUS);
        end else if (esus_set && is_erase) begin
          pe_nxt  = fopc_pkg::FOPC_STOP;
          pe_load = 1'b1;
          pe_cnt  = 16'(`FOPC_C_ESUS);
        end else if (pe_exp) begin
          pe_nxt   = fopc_pkg::FOPC_IDLE;
          done_nxt = 1'b1;
        end
      end
      fopc_pkg::FOPC_STOP: begin
        if (pe_exp) begin
          pe_nxt   = ctrl_r[`FOPC_B_HVE] ? fopc_pkg::FOPC_SUSP : fopc_pkg::FOPC_IDLE;
          done_nxt = 1'b1;
        end
      end
      fopc_pkg::FOPC_SUSP: begin
        if (sus_clr) begin
          pe_nxt   = fopc_pkg::FOPC_RUN;
          done_nxt = 1'b0;
          pe_load  = 1'b1;
        end else if (hv_fall) begin
          pe_nxt = fopc_pkg::FOPC_IDLE;
        end
      end
      default: begin
        pe_nxt   = fopc_pkg::FOPC_IDLE;
        done_nxt = 1'b1;
      end
    endcase
  end

  // Resumed operations restart the full length; the remaining time is not kept
  fopc_timer u_pe_tmr (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_load    (pe_load),
    .i_count   (pe_cnt),
    .i_cancel  (1'b0),
    .o_expire  (pe_exp),
    .o_busy    ()
  );

  // Integrity check sequencer
  fopc_pkg::fopc_state_t ai_r;
  fopc_pkg::fopc_state_t ai_nxt;
  logic        aid_r;
  logic        aid_nxt;
  logic        ai_load;
  logic [15:0] ai_cnt;
  wire         ai_exp;
  wire         is_mr = ctrl_r[`FOPC_B_MRSEL];
  wire [15:0]  stop_cnt = is_mr ? 16'(`FOPC_C_MRSTOP) : 16'(`FOPC_C_AISTOP);

  always_comb begin
    ai_nxt  = ai_r;
    aid_nxt = aid_r;
    ai_load = 1'b0;
    ai_cnt  = oplen_r;
    case (ai_r)
      fopc_pkg::FOPC_IDLE: begin
        if (ai_rise) begin
          ai_nxt  = fopc_pkg::FOPC_RUN;
          aid_nxt = 1'b0;
          ai_load = 1'b1;
        end
      end
      fopc_pkg::FOPC_RUN: begin
        if (ai_fall || ais_set) begin
          ai_nxt  = fopc_pkg::FOPC_STOP;
          ai_load = 1'b1;
          ai_cnt  = stop_cnt;
        end else if (bk_s2_r && !ctrl_r[`FOPC_B_NO_BKPT]) begin
          ai_nxt  = fopc_pkg::FOPC_HALT;
          aid_nxt = 1'b1;
        end else if (ai_exp) begin
          ai_nxt  = fopc_pkg::FOPC_IDLE;
          aid_nxt = 1'b1;
        end
      end
      fopc_pkg::FOPC_STOP: begin
        if (ai_exp) begin
          ai_nxt  = ctrl_r[`FOPC_B_CHK_EN] ? fopc_pkg::FOPC_SUSP : fopc_pkg::FOPC_IDLE;
          aid_nxt = 1'b1;
        end
      end
      fopc_pkg::FOPC_SUSP, fopc_pkg::FOPC_HALT: begin
        if (ai_resume && bus.wdata[`FOPC_B_CHK_EN]) begin
          ai_nxt  = fopc_pkg::FOPC_RUN;
          aid_nxt = 1'b0;
          ai_load = 1'b1;
        end else if (ai_fall) begin
          ai_nxt = fopc_pkg::FOPC_IDLE;
        end
      end
      default: begin
        ai_nxt  = fopc_pkg::FOPC_IDLE;
        aid_nxt = 1'b1;
      end
    endcase
  end

  fopc_timer u_ai_tmr (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_load    (ai_load),
    .i_count   (ai_cnt),
    .i_cancel  (1'b0),
    .o_expire  (ai_exp),
    .o_busy    ()
  );

  // Low power recovery
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rec_r   <= 16'h0000;
      ready_r <= 1'b1;
    end else if (lp_exit) begin
      rec_r   <= 16'(`FOPC_C_DROV);
      ready_r <= 1'b0;
    end else if (ctrl_r[`FOPC_B_LOWPWR]) begin
      ready_r <= 1'b0;
    end else if (rec_r != 16'h0000) begin
      rec_r   <= rec_r - 16'h0001;
      ready_r <= rec_r == 16'h0001;
    end
  end

  // Interrupt events: completion edges and recovery end
  wire [2:0] ev;
  assign ev[`FOPC_I_DONE]  = done_nxt && !done_r;
  assign ev[`FOPC_I_CHK_FIN] = aid_nxt && !aid_r;
  assign ev[`FOPC_I_READY] = (rec_r == 16'h0001) && !ctrl_r[`FOPC_B_LOWPWR];
  wire rd_ist = bus.rd && sel_ist;

  assign status = {22'h0, ai_r != fopc_pkg::FOPC_IDLE, aid_r, 5'h00,
                   ready_r, pe_r != fopc_pkg::FOPC_IDLE, done_r};
  wire [31:0] rd_mux = sel_ctrl ? ctrl_r :
                       sel_stat ? status :
                       sel_ist  ? {29'h0, ist_r} :
                       sel_mask ? {29'h0, mask_r} :
                       sel_cfg  ? {16'h0, oplen_r} : 32'h0000_0000;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ctrl_r  <= `FOPC_CTRL_RST;
      pe_r    <= fopc_pkg::FOPC_IDLE;
      ai_r    <= fopc_pkg::FOPC_IDLE;
      done_r  <= 1'b1;
      aid_r   <= 1'b1;
      ist_r   <= 3'h0;
      mask_r  <= `FOPC_MASK_RST;
      oplen_r <= `FOPC_OPLEN_RST;
      rdata_r <= 32'h0000_0000;
      o_irq   <= 1'b0;
      o_hv_on <= 1'b0;
      o_ai_run <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      pe_r    <= pe_nxt;
      ai_r    <= ai_nxt;
      done_r  <= done_nxt;
      aid_r   <= aid_nxt;
      // New event wins over the read clear
      ist_r   <= (rd_ist ? 3'h0 : ist_r) | ev;
      if (bus.wr && sel_mask)
        mask_r <= bus.wdata[2:0];
      if (bus.wr && sel_cfg)
        oplen_r <= bus.wdata[15:0];
      rdata_r <= bus.rd ? rd_mux : 32'h0000_0000;
      o_irq   <= |(((rd_ist ? 3'h0 : ist_r) | ev) & (bus.wr && sel_mask ? bus.wdata[2:0] : mask_r));
      // Stays up while winding down, so the drop marks completion
      o_hv_on <= pe_nxt == fopc_pkg::FOPC_RUN || pe_nxt == fopc_pkg::FOPC_STOP;
      o_ai_run <= ai_nxt == fopc_pkg::FOPC_RUN || ai_nxt == fopc_pkg::FOPC_STOP;
    end
  end

  assign o_rdata = rdata_r;
endmodule

//--- fopc_core_properties.sv
// Port-level timing checks of the flash sequencer
`timescale 1ns/1ps
`include "fopc_params.svh"
module fopc_core_properties (
  input wire logic        i_ref_clk,
  input wire logic        i_rst_n,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic        i_ai_bkpt,
  input wire logic [31:0] o_rdata,
  input wire logic        o_irq,
  input wire logic        o_hv_on,
  input wire logic        o_ai_run
);
  localparam int HV = `FOPC_B_HVE, ER = `FOPC_B_ERASE, PS = `FOPC_B_PSUS, ES = `FOPC_B_ESUS;
  localparam int LP = `FOPC_B_LOWPWR, AE = `FOPC_B_CHK_EN, AS = `FOPC_B_CHK_SUS;
  localparam int MR = `FOPC_B_MRSEL;
  logic [31:0] ctrl_r;
  logic [2:0]  mask_r;
  logic [15:0] rec_r, pe_n_r, ai_n_r, pe_x_r, ai_x_r;
  logic        pe_p_r, ai_p_r;
  wire logic [31:0] w = i_wdata;
  wire logic [31:0] c = ctrl_r;
  wire logic wc = i_wr && i_addr == `FOPC_OFF_CTRL;
  wire logic hv_up = wc && w[HV] && !c[HV];
  wire logic hv_dn = wc && !w[HV] && c[HV];
  wire logic ai_up = wc && w[AE] && !c[AE];
  wire logic ai_dn = wc && !w[AE] && c[AE];
  wire logic ps_up = wc && w[PS] && !c[PS];
  wire logic es_up = wc && w[ES] && !c[ES];
  wire logic as_up = wc && w[AS] && !c[AS];
  wire logic res_pe = wc && c[HV] && w[HV] && (c[PS] && !w[PS] || c[ES] && !w[ES]);
  wire logic res_ai = wc && c[AE] && w[AE] && c[AS] && !w[AS];
  wire logic pe_stop = o_hv_on && (ps_up && !c[ER] || es_up && c[ER] || hv_dn && !c[PS] && !c[ES]);
  wire logic ai_stop = o_ai_run && (as_up || ai_dn && !c[AS]);
  // Recovery shadow outlasts the design by a few cycles so neither check can misfire
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ctrl_r <= `FOPC_CTRL_RST;
      mask_r <= `FOPC_MASK_RST;
      rec_r  <= 16'h0;
      pe_p_r <= 1'h0;
      ai_p_r <= 1'h0;
    end else begin
      if (wc) ctrl_r <= w;
      if (i_wr && i_addr == `FOPC_OFF_IRQ_MASK) mask_r <= w[2:0];
      if (wc && c[LP] && !w[LP]) rec_r <= 16'(`FOPC_C_DROV + 4);
      else if (rec_r != 16'h0) rec_r <= rec_r - 16'h1;
      if (pe_stop) pe_p_r <= 1'h1;
      else if (!o_hv_on) pe_p_r <= 1'h0;
      if (ai_stop) ai_p_r <= 1'h1;
      else if (!o_ai_run) ai_p_r <= 1'h0;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    pe_n_r <= pe_stop ? 16'h0 : pe_n_r + 16'h1;
    ai_n_r <= ai_stop ? 16'h0 : ai_n_r + 16'h1;
    if (pe_stop) pe_x_r <= ps_up ? 16'(`FOPC_C_PSUS) : 16'(`FOPC_C_ESUS);
    if (ai_stop) ai_x_r <= c[MR] ? 16'(`FOPC_C_MRSTOP) : 16'(`FOPC_C_AISTOP);
  end
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_rdata_idle_zero: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_irq_masked_quiet: assert property ((mask_r == 3'h0) [*2] |-> !o_irq)
    else $error("interrupt high while fully masked");
  a_start_hv_on: assert property (
    hv_up && rec_r == 16'h0 && !c[LP] && !o_hv_on && !o_ai_run |=> o_hv_on)
    else $error("start did not raise high voltage");
  a_hv_needs_start: assert property (!o_hv_on && !hv_up && !res_pe |=> !o_hv_on)
    else $error("high voltage rose without a start");
  a_recov_refuse: assert property (hv_up && rec_r > 16'h8 |=> !o_hv_on)
    else $error("start accepted during recovery");
  a_resume_hv_on: assert property (res_pe && !o_hv_on |-> ##[1:2] o_hv_on)
    else $error("resume did not restart operation");
  a_pe_stop_time: assert property ($fell(o_hv_on) && pe_p_r |->
    pe_n_r + 16'h3 >= pe_x_r && pe_n_r <= pe_x_r + 16'h3)
    else $error("suspend or abort took wrong time");
  a_ai_start_run: assert property (ai_up && !o_ai_run && !o_hv_on |=> o_ai_run)
    else $error("check start did not run");
  a_ai_resume_run: assert property (res_ai && !o_ai_run |=> o_ai_run)
    else $error("check resume did not run");
  a_ai_stop_time: assert property ($fell(o_ai_run) && ai_p_r |->
    ai_n_r + 16'h3 >= ai_x_r && ai_n_r <= ai_x_r + 16'h3)
    else $error("check stop took wrong time");
  cover property (pe_stop && es_up);
  cover property (ai_stop && c[MR]);
  cover property (hv_up && rec_r > 16'h8);
endmodule

//--- fopc_array_model.sv
// Flash array stand-in driving the breakpoint request line
`timescale 1ns/1ps
module fopc_array_model (
  input  wire logic i_halt_req,
  output logic      o_bkpt
);
  // Off-grid delay so the synchroniser sees a truly asynchronous edge
  initial o_bkpt = 1'h0;
  always @(i_halt_req) o_bkpt <= #13 i_halt_req;
endmodule

//--- flash_op_control_timing_tb_top.sv
// Self-checking bench for the flash sequencer
`timescale 1ns/1ps
`include "fopc_params.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module flash_op_control_timing_tb_top;
  localparam logic [31:0] HV = 32'h1 << `FOPC_B_HVE, ER = 32'h1 << `FOPC_B_ERASE;
  localparam logic [31:0] PS = 32'h1 << `FOPC_B_PSUS, ES = 32'h1 << `FOPC_B_ESUS;
  localparam logic [31:0] LP = 32'h1 << `FOPC_B_LOWPWR, AE = 32'h1 << `FOPC_B_CHK_EN;
  localparam logic [31:0] AS = 32'h1 << `FOPC_B_CHK_SUS, NB = 32'h1 << `FOPC_B_NO_BKPT;
  localparam logic [31:0] MR = 32'h1 << `FOPC_B_MRSEL;
  logic        i_ref_clk, i_rst_n, i_wr, i_rd, i_ai_bkpt, bk_req;
  logic        o_irq, o_hv_on, o_ai_run;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, o_rdata;
  int          fails, n_compared;
  fopc_core uut (.i_ref_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .i_ai_bkpt,
                 .o_rdata, .o_irq, .o_hv_on, .o_ai_run);
  fopc_array_model flash (.i_halt_req(bk_req), .o_bkpt(i_ai_bkpt));
  initial begin
    i_ref_clk = 1'h0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // Gap edge after each write keeps strobes from being driven twice in one step
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_ref_clk);
    i_wr <= 1'h0;
    @(posedge i_ref_clk);
  endtask
  task automatic rd32(input logic [7:0] a, output logic [31:0] d);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_ref_clk);
    i_rd <= 1'h0;
    #1 d = o_rdata;
    @(posedge i_ref_clk);
  endtask
  task automatic wait_low(input logic ai, output int n);
    n = 0;
    while ((ai ? o_ai_run : o_hv_on) !== 1'h0 && n < 3000) begin
      @(posedge i_ref_clk);
      n++;
    end
  endtask
  task automatic stop_chk(input logic [31:0] w, input logic ai, input int c, input int b);
    int n;
    logic [31:0] s;
    wr32(`FOPC_OFF_CTRL, w);
    wait_low(ai, n);
    `CHK(n inside {[c - 3 : c + 3]}, 1'h1)
    rd32(`FOPC_OFF_STAT, s);
    `CHK(s[b], 1'h1)
  endtask
  task automatic t_reset;
    logic [31:0] s;
    rd32(`FOPC_OFF_STAT, s);
    `CHK(s[`FOPC_S_DONE], 1'h1)
    `CHK(s[`FOPC_S_CHK_FIN], 1'h1)
    `CHK(s[`FOPC_S_READY], 1'h1)
    rd32(`FOPC_OFF_CONFIG, s);
    `CHK(s[15:0], `FOPC_OPLEN_RST)
    rd32(`FOPC_OFF_IRQ_MASK, s);
    `CHK(s[2:0], `FOPC_MASK_RST)
    rd32(8'h20, s);
    `CHK(s, 32'h0)
  endtask
  task automatic t_program;
    logic [31:0] s;
    int n;
    wr32(`FOPC_OFF_CTRL, HV);
    rd32(`FOPC_OFF_STAT, s);
    `CHK(s[`FOPC_S_DONE], 1'h0)
    stop_chk(HV | PS, 1'h0, `FOPC_C_PSUS, `FOPC_S_DONE);
    wr32(`FOPC_OFF_CTRL, HV);
    rd32(`FOPC_OFF_STAT, s);
    `CHK(s[`FOPC_S_DONE], 1'h0)
    wait_low(1'h0, n);
    `CHK(n < 400, 1'h1)
    rd32(`FOPC_OFF_STAT, s);
    `CHK(s[`FOPC_S_DONE], 1'h1)
    wr32(`FOPC_OFF_CTRL, 32'h0);
  endtask
  task automatic t_erase;
    wr32(`FOPC_OFF_CTRL, HV | ER);
    stop_chk(HV | ER | ES, 1'h0, `FOPC_C_ESUS, `FOPC_S_DONE);
    wr32(`FOPC_OFF_CTRL, HV | ER);
    stop_chk(ER, 1'h0, `FOPC_C_ESUS, `FOPC_S_DONE);
    wr32(`FOPC_OFF_CTRL, 32'h0);
  endtask
  task automatic t_check;
    logic [31:0] s;
    wr32(`FOPC_OFF_CTRL, AE);
    rd32(`FOPC_OFF_STAT, s);
    `CHK(s[`FOPC_S_CHK_FIN], 1'h0)
    stop_chk(AE | AS, 1'h1, `FOPC_C_AISTOP, `FOPC_S_CHK_FIN);
    wr32(`FOPC_OFF_CTRL, AE);
    rd32(`FOPC_OFF_STAT, s);
    `CHK(s[`FOPC_S_CHK_FIN], 1'h0)
    stop_chk(32'h0, 1'h1, `FOPC_C_AISTOP, `FOPC_S_CHK_FIN);
  endtask
  task automatic t_margin;
    wr32(`FOPC_OFF_CTRL, AE | MR);
    stop_chk(AE | MR | AS, 1'h1, `FOPC_C_MRSTOP, `FOPC_S_CHK_FIN);
    wr32(`FOPC_OFF_CTRL, AE | MR);
    stop_chk(MR, 1'h1, `FOPC_C_MRSTOP, `FOPC_S_CHK_FIN);
    wr32(`FOPC_OFF_CTRL, 32'h0);
  endtask
  task automatic t_bkpt;
    logic [31:0] s;
    wr32(`FOPC_OFF_CTRL, AE | NB);
    bk_req <= 1'h1;
    repeat (20) @(posedge i_ref_clk);
    `CHK(o_ai_run, 1'h1)
    wr32(`FOPC_OFF_CTRL, AE);
    rd32(`FOPC_OFF_STAT, s);
    `CHK(s[`FOPC_S_CHK_FIN], 1'h1)
    `CHK(o_ai_run, 1'h0)
    bk_req <= 1'h0;
    repeat (4) @(posedge i_ref_clk);
    wr32(`FOPC_OFF_CTRL, AE | NB);
    wr32(`FOPC_OFF_CTRL, AE);
    rd32(`FOPC_OFF_STAT, s);
    `CHK(s[`FOPC_S_CHK_FIN], 1'h0)
    stop_chk(32'h0, 1'h1, `FOPC_C_AISTOP, `FOPC_S_CHK_FIN);
    wr32(`FOPC_OFF_CTRL, 32'h0);
  endtask
  task automatic t_lowpwr;
    logic [31:0] s;
    int n;
    rd32(`FOPC_OFF_IRQ_STAT, s);
    `CHK(s[2:0], 3'h3)
    `CHK(o_irq, 1'h0)
    wr32(`FOPC_OFF_IRQ_MASK, 32'h4);
    wr32(`FOPC_OFF_CTRL, LP);
    wr32(`FOPC_OFF_CTRL, 32'h0);
    wr32(`FOPC_OFF_CTRL, HV);
    rd32(`FOPC_OFF_STAT, s);
    `CHK(s[`FOPC_S_READY], 1'h0)
    `CHK(o_hv_on, 1'h0)
    wr32(`FOPC_OFF_CTRL, 32'h0);
    n = 0;
    while (o_irq !== 1'h1 && n < 3000) begin
      @(posedge i_ref_clk);
      n++;
    end
    `CHK(n inside {[`FOPC_C_DROV - 12 : `FOPC_C_DROV]}, 1'h1)
    rd32(`FOPC_OFF_IRQ_STAT, s);
    `CHK(s[2:0], 3'h4)
    rd32(`FOPC_OFF_IRQ_STAT, s);
    `CHK(s[2:0], 3'h0)
    `CHK(o_irq, 1'h0)
  endtask
  task automatic summarize;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge i_ref_clk);
    fails++;
    summarize();
  end
  initial begin
    i_rst_n = 1'h0;
    i_wr = 1'h0;
    i_rd = 1'h0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    bk_req = 1'h0;
    repeat (8) @(posedge i_ref_clk);
    i_rst_n <= 1'h1;
    @(posedge i_ref_clk);
    t_reset();
    t_program();
    t_erase();
    t_check();
    t_margin();
    t_bkpt();
    t_lowpwr();
    summarize();
  end
endmodule
bind fopc_core fopc_core_properties chk (.i_ref_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr,
  .i_rd, .i_ai_bkpt, .o_rdata, .o_irq, .o_hv_on, .o_ai_run);
